// file: tml_pkg.sv
// What this block does
// - Start marker flag is high while the start marker sensor sees the marker.
// - A falling start marker flag gives one 1 us pulse on its own output.
// - End marker flag is high while the end marker sensor sees the marker.
// - Tape broken flag follows the broken indication from the sequence controller.
// - Tape broken flag is held high straight after power-on.
// - Protect state is caught only when the broken flag falls, then held.
// - A grounded protect contact (no write ring) is caught as protected.
// - Head drives are on only with the contact open and write permit high.
// - Losing supply power removes both head drives together at the next enabled clock.
package tml_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h004;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
	localparam logic [11:0] ADDR_CTRL = 12'h00C;

	// Interrupt status and mask bit positions.
	localparam int IRQ_START_ON = 0;
	localparam int IRQ_START_OFF = 1;
	localparam int IRQ_END_ON = 2;
	localparam int IRQ_BROKEN_ON = 3;
	localparam int IRQ_POWER_LOSS = 4;
	localparam int IRQ_W = 5;

	// Control register field and reset values.
	localparam int CTRL_HEAD_INHIBIT = 0;
	localparam logic CTRL_INHIBIT_RST = 1'b0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
	localparam logic BROKEN_RST = 1'b1;
	localparam logic PROTECT_RST = 1'b1;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ = 10;
	localparam int PULSE_NS = 1000;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_STAGES = 2;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic end_mark;
		logic start_mark;
	} tml_sense_t;

	typedef struct packed {
		logic power_loss;
		logic drives_on;
		logic protect;
		logic broken;
		logic end_mark;
		logic start_mark;
	} tml_status_t;
endpackage : tml_pkg

// file: tml_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tml_sync #(
	parameter int WIDTH = 2,
	parameter int STAGES = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	if (STAGES < 2 || WIDTH < 1) begin : g_bad
		$error("tml_sync needs at least two stages and one bit");
	end

	logic [WIDTH-1:0] stage_r [STAGES];

	// Stage 0 is read only by stage 1.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_r[i] <= '0;
			end
		end else if (ce) begin
			stage_r[0] <= d;
			for (int i = 1; i < STAGES; i++) begin
				stage_r[i] <= stage_r[i-1];
			end
		end
	end

	assign q = stage_r[STAGES-1];
endmodule : tml_sync
`default_nettype wire

// file: tml_trail_pulse.sv
`timescale 1ns/100ps
`default_nettype none
module tml_trail_pulse #(
	parameter int CYC = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic level,
	output logic pulse
);
	localparam int CW = $clog2(CYC + 1);

	if (CYC < 1) begin : g_bad
		$error("tml_trail_pulse needs a length of at least one cycle");
	end

	logic prev_r;
	logic pulse_r;
	logic [CW-1:0] cnt_r;
	wire fall = prev_r & ~level;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			pulse_r <= 1'b0;
			cnt_r <= '0;
		end else if (ce) begin
			prev_r <= level;
			if (fall) begin
				pulse_r <= 1'b1;
				cnt_r <= CW'(CYC - 1);
			end else if (cnt_r != '0) begin
				cnt_r <= cnt_r - CW'(1);
			end else begin
				pulse_r <= 1'b0;
			end
		end
	end

	assign pulse = pulse_r;
endmodule : tml_trail_pulse
`default_nettype wire

// file: tml_marker_top.sv
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tml_marker_top #(
	parameter int PULSE_CYC = tml_pkg::PULSE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic start_sensor,
	input wire logic end_sensor,
	input wire logic broken_in,
	input wire logic protect_contact_gnd,
	input wire logic write_permit,
	input wire logic power_loss,
	output logic start_marker_flag,
	output logic start_trail_pulse,
	output logic end_marker_flag,
	output logic tape_broken_flag,
	output logic write_protect_flag,
	output logic write_drive_en,
	output logic erase_drive_en,
	output logic irq
);
	if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad
		$error("tml_marker_top pulse length must be 1 to 255 cycles");
	end

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_q1_r;
	logic rst_n;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_q1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1_r <= 1'b1;
			rst_n <= rst_q1_r;
		end
	end

	// ****************************************************************
	// Sensor synchronisers
	// ****************************************************************
	tml_pkg::tml_sense_t sense_raw;
	tml_pkg::tml_sense_t sense_s;

	assign sense_raw.start_mark = start_sensor;
	assign sense_raw.end_mark = end_sensor;

	tml_sync #(
		.WIDTH($bits(tml_pkg::tml_sense_t)),
		.STAGES(tml_pkg::SYNC_STAGES)
	) u_sense_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(sense_raw),
		.q(sense_s)
	);

	// ****************************************************************
	// Marker and broken flags
	// ****************************************************************
	logic start_flag_r;
	logic end_flag_r;
	logic broken_r;
	logic protect_r;

	wire broken_fall = broken_r & ~broken_in;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_flag_r <= 1'b0;
			end_flag_r <= 1'b0;
		end else if (ce) begin
			start_flag_r <= sense_s.start_mark;
			end_flag_r <= sense_s.end_mark;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			broken_r <= tml_pkg::BROKEN_RST;
		end else if (ce) begin
			broken_r <= broken_in;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			protect_r <= tml_pkg::PROTECT_RST;
		end else if (ce && broken_fall) begin
			protect_r <= protect_contact_gnd;
		end
	end

	// trailing edge pulse of start flag
	tml_trail_pulse #(
		.CYC(PULSE_CYC)
	) u_trail (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.level(start_flag_r),
		.pulse(start_trail_pulse)
	);

	// ****************************************************************
	// Head drives
	// ****************************************************************
	logic drive_r;
	logic power_prev_r;
	logic inhibit_r;

	// drives need open contact and permit
	wire drive_nxt = ~protect_contact_gnd & write_permit & ~power_loss & ~inhibit_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_r <= 1'b0;
			power_prev_r <= 1'b0;
		end else if (ce) begin
			drive_r <= drive_nxt;
			power_prev_r <= power_loss;
		end
	end

	// ****************************************************************
	// Events
	// ****************************************************************
	logic [tml_pkg::IRQ_W-1:0] events;

	assign events[tml_pkg::IRQ_START_ON] = sense_s.start_mark & ~start_flag_r;
	assign events[tml_pkg::IRQ_START_OFF] = ~sense_s.start_mark & start_flag_r;
	assign events[tml_pkg::IRQ_END_ON] = sense_s.end_mark & ~end_flag_r;
	assign events[tml_pkg::IRQ_BROKEN_ON] = broken_in & ~broken_r;
	assign events[tml_pkg::IRQ_POWER_LOSS] = power_loss & ~power_prev_r;

	// ****************************************************************
	// APB slave
	// ****************************************************************
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [tml_pkg::IRQ_W-1:0] irq_stat_r;
	logic [tml_pkg::IRQ_W-1:0] irq_mask_r;
	logic irq_r;
	tml_pkg::tml_status_t status;

	wire acc = psel & penable & ~pready_r;
	wire wr_fire = psel & penable & pready_r & pwrite;
	wire sel_status = paddr == tml_pkg::ADDR_STATUS;
	wire sel_irq_stat = paddr == tml_pkg::ADDR_IRQ_STAT;
	wire sel_irq_mask = paddr == tml_pkg::ADDR_IRQ_MASK;
	wire sel_ctrl = paddr == tml_pkg::ADDR_CTRL;
	wire hit = sel_status | sel_irq_stat | sel_irq_mask | sel_ctrl;

	assign status.power_loss = power_prev_r;
	assign status.drives_on = drive_r;
	assign status.protect = protect_r;
	assign status.broken = broken_r;
	assign status.end_mark = end_flag_r;
	assign status.start_mark = start_flag_r;

	wire [31:0] rd_data = sel_status ? 32'(status) :
		sel_irq_stat ? 32'(irq_stat_r) :
		sel_irq_mask ? 32'(irq_mask_r) :
		sel_ctrl ? 32'(inhibit_r) : 32'h0000_0000;

	wire [tml_pkg::IRQ_W-1:0] w1c = (wr_fire && sel_irq_stat) ?
		pwdata[tml_pkg::IRQ_W-1:0] : '0;

	// A new event in the clearing cycle wins over the clear.
	wire [tml_pkg::IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~w1c) | events;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (ce) begin
			pready_r <= acc;
			pslverr_r <= acc & ~hit;
			prdata_r <= (acc && !pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_r <= '0;
			irq_mask_r <= tml_pkg::IRQ_MASK_RST;
			inhibit_r <= tml_pkg::CTRL_INHIBIT_RST;
			irq_r <= 1'b0;
		end else if (ce) begin
			irq_stat_r <= irq_stat_nxt;
			irq_r <= |(irq_stat_r & irq_mask_r);
			if (wr_fire && sel_irq_mask) begin
				irq_mask_r <= pwdata[tml_pkg::IRQ_W-1:0];
			end
			if (wr_fire && sel_ctrl) begin
				inhibit_r <= pwdata[tml_pkg::CTRL_HEAD_INHIBIT];
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign start_marker_flag = start_flag_r;
	assign end_marker_flag = end_flag_r;
	assign tape_broken_flag = broken_r;
	assign write_protect_flag = protect_r;
	assign write_drive_en = drive_r;
	assign erase_drive_en = drive_r;
	assign irq = irq_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	logic [7:0] pulse_len_r;

	// Counts enabled cycles for which the trailing pulse has been high.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_len_r <= 8'h00;
		end else if (!start_trail_pulse) begin
			pulse_len_r <= 8'h00;
		end else if (ce && pulse_len_r != 8'hFF) begin
			pulse_len_r <= pulse_len_r + 8'h01;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_flag_fall;
		ce && $fell(start_marker_flag);
	endsequence

	sequence s_pulse_end;
		$fell(start_trail_pulse);
	endsequence

	a_start_flag: assert property (ce |=> start_marker_flag == $past(sense_s.start_mark))
		else $error("start flag does not follow its sensor");

	a_trail_start: assert property (s_flag_fall |=> start_trail_pulse)
		else $error("no pulse after start flag fell");

	a_trail_length: assert property (s_pulse_end |-> pulse_len_r >= 8'(PULSE_CYC))
		else $error("trailing pulse shorter than its length");

	a_end_flag: assert property (ce |=> end_marker_flag == $past(sense_s.end_mark))
		else $error("end flag does not follow its sensor");

	a_broken_follow: assert property (ce |=> tape_broken_flag == $past(broken_in))
		else $error("broken flag does not follow its input");

	a_broken_poweron: assert property ($rose(rst_n) |-> tape_broken_flag)
		else $error("broken flag low right after reset");

	a_protect_catch: assert property (ce && broken_fall |=>
		write_protect_flag == $past(protect_contact_gnd))
		else $error("protect state not caught when broken fell");

	a_protect_hold: assert property (!(ce && broken_fall) |=> $stable(write_protect_flag))
		else $error("protect state changed without a load");

	a_drive_gate: assert property (ce && (protect_contact_gnd || !write_permit) |=>
		!write_drive_en && !erase_drive_en)
		else $error("head drives on without open contact and permit");

	a_power_cut: assert property (ce && power_loss |=> !write_drive_en ##1 1'b1)
		else $error("head drives still on during power loss");

	a_irq_level: assert property (ce |=> irq == $past(|(irq_stat_r & irq_mask_r)))
		else $error("interrupt output does not match masked status");
endmodule : tml_marker_top
`default_nettype wire

// file: tml_pb_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Pushbutton and interface control stand-in
// ****************************************************************
module tml_pb_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic want_write,
	input wire logic write_protect_flag,
	input wire logic start_trail_pulse,
	output logic write_permit,
	output logic [7:0] pulse_rises,
	output logic [7:0] pulse_cycles
);
	logic pulse_d;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			write_permit <= 1'b0;
		end else begin
			write_permit <= want_write && !write_protect_flag;
		end
	end

	// Counts pulses and pulse length so the bench can judge them.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pulse_d <= 1'b0;
			pulse_rises <= 8'h00;
			pulse_cycles <= 8'h00;
		end else begin
			pulse_d <= start_trail_pulse;
			if (start_trail_pulse && !pulse_d) begin
				pulse_rises <= pulse_rises + 8'h01;
			end
			if (start_trail_pulse) begin
				pulse_cycles <= pulse_cycles + 8'h01;
			end
		end
	end
endmodule : tml_pb_model
`default_nettype wire

// file: tape_marker_and_write_protect_logic_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tape_marker_and_write_protect_logic_bench;
	localparam int PC = tml_pkg::PULSE_CYC;
	logic clk = 1'b0;
	logic ce = 1'b1;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, er;
	logic start_sensor = 1'b0, end_sensor = 1'b0, broken_in = 1'b1;
	logic contact = 1'b1, power_loss = 1'b0, want_write = 1'b0, write_permit;
	logic start_flag, trail, end_flag, broken_flag, protect_flag, wdrv, edrv, irq;
	logic [7:0] rises, cycles;
	int err_total = 0;
	int check_count = 0;

	always #50 clk = ~clk;

	tml_marker_top #(.PULSE_CYC(PC)) u_dut (.clk(clk), .resetn(resetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.start_sensor(start_sensor), .end_sensor(end_sensor), .broken_in(broken_in),
		.protect_contact_gnd(contact), .write_permit(write_permit),
		.power_loss(power_loss), .start_marker_flag(start_flag),
		.start_trail_pulse(trail), .end_marker_flag(end_flag),
		.tape_broken_flag(broken_flag), .write_protect_flag(protect_flag),
		.write_drive_en(wdrv), .erase_drive_en(edrv), .irq(irq));

	tml_pb_model u_pb (.clk(clk), .resetn(resetn), .want_write(want_write),
		.write_protect_flag(protect_flag), .start_trail_pulse(trail),
		.write_permit(write_permit), .pulse_rises(rises), .pulse_cycles(cycles));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		if (n >= 50) chk("apb answer", 32'h00000001, 32'h00000000);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic drives(input logic exp);
		chk("write drive", {31'h0, exp}, {31'h0, wdrv});
		chk("erase drive", {31'h0, exp}, {31'h0, edrv});
	endtask : drives

	task automatic end_sim;
		$display("checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		cyc(3);
		chk("broken at power-on", 32'h1, {31'h0, broken_flag});
		chk("protect at power-on", 32'h1, {31'h0, protect_flag});
		cyc(3);
		resetn <= 1'b1;
		cyc(4);
		apb(1'b0, tml_pkg::ADDR_STATUS, 32'h0);
		chk("status after reset", 32'h0000000C, rd);
		chk("status error", 32'h0, {31'h0, er});
		apb(1'b0, tml_pkg::ADDR_IRQ_MASK, 32'h0);
		chk("mask reset", 32'h0, rd);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("test reset done");
		// Load a reel without its write ring; sequence controller ends the load.
		want_write <= 1'b1;
		broken_in <= 1'b0;
		cyc(3);
		chk("broken follows", 32'h0, {31'h0, broken_flag});
		chk("protect caught", 32'h1, {31'h0, protect_flag});
		contact <= 1'b0;
		cyc(4);
		chk("protect held", 32'h1, {31'h0, protect_flag});
		drives(1'b0);
		$display("test protected load done");
		// Tape break then reload with the ring fitted.
		broken_in <= 1'b1;
		cyc(3);
		chk("broken raised", 32'h1, {31'h0, broken_flag});
		broken_in <= 1'b0;
		cyc(5);
		chk("protect cleared", 32'h0, {31'h0, protect_flag});
		drives(1'b1);
		contact <= 1'b1;
		cyc(3);
		drives(1'b0);
		chk("protect kept", 32'h0, {31'h0, protect_flag});
		contact <= 1'b0;
		cyc(3);
		drives(1'b1);
		power_loss <= 1'b1;
		cyc(2);
		drives(1'b0);
		power_loss <= 1'b0;
		apb(1'b1, tml_pkg::ADDR_CTRL, 32'h1);
		cyc(2);
		drives(1'b0);
		apb(1'b1, tml_pkg::ADDR_CTRL, 32'h0);
		cyc(2);
		drives(1'b1);
		$display("test head drives done");
		// Markers, trailing pulse and interrupt.
		apb(1'b1, tml_pkg::ADDR_IRQ_MASK, 32'h1 << tml_pkg::IRQ_END_ON);
		ce <= 1'b0;
		start_sensor <= 1'b1;
		cyc(5);
		chk("start flag frozen", 32'h0, {31'h0, start_flag});
		ce <= 1'b1;
		cyc(5);
		chk("start flag on", 32'h1, {31'h0, start_flag});
		start_sensor <= 1'b0;
		cyc(5);
		chk("start flag off", 32'h0, {31'h0, start_flag});
		cyc(15);
		chk("pulse count", 32'h1, {24'h0, rises});
		chk("pulse length", PC, {24'h0, cycles});
		chk("irq masked", 32'h0, {31'h0, irq});
		end_sensor <= 1'b1;
		cyc(5);
		chk("end flag on", 32'h1, {31'h0, end_flag});
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b0, tml_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("irq status", 32'h0000001F, rd);
		apb(1'b1, tml_pkg::ADDR_IRQ_STAT, 32'h0000001F);
		cyc(3);
		chk("irq cleared", 32'h0, {31'h0, irq});
		end_sensor <= 1'b0;
		cyc(5);
		chk("end flag off", 32'h0, {31'h0, end_flag});
		$display("test markers done");
		// Second reset in mid-run; the controller has the load finished already.
		resetn <= 1'b0;
		cyc(2);
		chk("broken in reset", 32'h1, {31'h0, broken_flag});
		chk("protect in reset", 32'h1, {31'h0, protect_flag});
		resetn <= 1'b1;
		cyc(2);
		chk("broken at release", 32'h1, {31'h0, broken_flag});
		cyc(2);
		chk("broken after release", 32'h0, {31'h0, broken_flag});
		chk("protect after release", 32'h0, {31'h0, protect_flag});
		$display("test second reset done");
		end_sim();
	end

	initial begin
		cyc(5000);
		err_total++;
		end_sim();
	end
endmodule : tape_marker_and_write_protect_logic_bench
`default_nettype wire
